// ==== lockout_pkg.sv ====
// shared constants and types for the lockout, reset and status logic
package lockout_pkg;

	// clock rate in kilohertz
	localparam int CLK_KHZ = 20000;

	// reset closure window, in milliseconds
	localparam int RESET_MIN_MS = 250;
	localparam int RESET_MAX_MS = 2000;
	// status indicator flash half period, in milliseconds
	localparam int FLASH_HALF_MS = 250;

	// cycle counts; ms times kHz is an exact count, so no rounding is needed
	localparam int RESET_MIN_CYCLES = RESET_MIN_MS * CLK_KHZ;
	localparam int RESET_MAX_CYCLES = RESET_MAX_MS * CLK_KHZ;
	localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;

	// hold counter width, enough for the longest window plus one
	localparam int CNT_W = 27;

	// number of inputs with an activity indicator
	localparam int NUM_INPUTS = 8;
	localparam int IDX_W = 3;

	// register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h0C;

	// control register fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_FORCE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// event bits in status and mask
	localparam int EV_W = 4;
	localparam int EV_LOCKOUT = 0;
	localparam int EV_ACCEPT = 1;
	localparam int EV_REJECT = 2;
	localparam int EV_CLEARED = 3;
	localparam logic [EV_W-1:0] EV_RESET = 4'h0;

	// state register fields
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_OUT_BIT = 1;
	localparam int ST_FAULT_BIT = 2;
	localparam int ST_CODE_LSB = 8;

	// error code shown for a software forced lockout
	localparam logic [7:0] CODE_FORCED = 8'h99;
	localparam logic [7:0] CODE_NONE = 8'h00;

	// lockout state machine
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_LOCK = 2'b01,
		MODE_CLEARWAIT = 2'b10
	} mode_t;

endpackage

// ==== reset_qual_if.sv ====
// handshake between the lockout control and the reset qualifier
`timescale 1ns/100ps
`default_nettype none
interface reset_qual_if;
	// synchronised reset switch, high while closed
	logic closed;
	// one-cycle pulse: a closure within the window was released
	logic valid;
	// one-cycle pulse: a closure too short or too long was released
	logic reject;
	modport qual (input closed, output valid, output reject);
	modport ctrl (output closed, input valid, input reject);
endinterface
`default_nettype wire

// ==== reset_qualifier.sv ====
// times a reset switch closure and judges it on release
`timescale 1ns/100ps
`default_nettype none
module reset_qualifier
	import lockout_pkg::*;
#(
	parameter int MIN_CYCLES = RESET_MIN_CYCLES,
	parameter int MAX_CYCLES = RESET_MAX_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// judged closures
	reset_qual_if.qual rq
);
	// cycles the switch has been closed, saturating past the window
	logic [CNT_W-1:0] held;
	// previous switch level, for release detection
	logic wasClosed;
	localparam logic [CNT_W-1:0] MIN_C = CNT_W'(MIN_CYCLES);
	localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYCLES);
	localparam logic [CNT_W-1:0] SAT_C = CNT_W'(MAX_CYCLES + 1);

	// hold timer; saturation keeps an overlong press from wrapping into the window
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held <= '0;
			wasClosed <= 1'b0;
		end else begin
			wasClosed <= rq.closed;
			if (!rq.closed)
				held <= '0;
			else if (held != SAT_C)
				held <= held + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rq.valid <= 1'b0;
			rq.reject <= 1'b0;
		end else begin
			rq.valid <= wasClosed && !rq.closed && held >= MIN_C && held <= MAX_C;
			rq.reject <= wasClosed && !rq.closed && (held < MIN_C || held > MAX_C);
		end
	end
endmodule
`default_nettype wire

// ==== blink_timer.sv ====
// free-running square wave for flashing indicators
`timescale 1ns/100ps
`default_nettype none
module blink_timer
	import lockout_pkg::*;
#(
	parameter int HALF_CYCLES = FLASH_HALF_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// flash phase, high in the lit half
	output logic phase
);
	// cycles elapsed in this half period
	logic [CNT_W-1:0] count;
	localparam logic [CNT_W-1:0] LAST_C = CNT_W'(HALF_CYCLES - 1);

	// one shared phase keeps red indicator and dash in step
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			phase <= 1'b1;
		end else if (count == LAST_C) begin
			count <= '0;
			phase <= !phase;
		end else begin
			count <= count + CNT_W'(1);
		end
	end
endmodule
`default_nettype wire

// ==== lockout_reset_status_logic.sv ====
// lockout control, reset acceptance and status indication of a muting module
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module lockout_reset_status_logic
#(
	parameter int RESET_MIN = lockout_pkg::RESET_MIN_CYCLES,
	parameter int RESET_MAX = lockout_pkg::RESET_MAX_CYCLES,
	parameter int FLASH_HALF = lockout_pkg::FLASH_HALF_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fault detection, from pins
	input wire logic faultIn,
	input wire logic [7:0] faultCode,
	input wire logic faultIsInput,
	input wire logic [lockout_pkg::IDX_W-1:0] faultIdx,
	// operator and input pins
	input wire logic resetClosed,
	input wire logic muteActive,
	input wire logic [lockout_pkg::NUM_INPUTS-1:0] activeIn,
	// register port
	input wire logic [lockout_pkg::ADDR_W-1:0] addr,
	input wire logic [lockout_pkg::DATA_W-1:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [lockout_pkg::DATA_W-1:0] rdData,
	output logic irq,
	// safety outputs to the machine
	output logic [1:0] safetyOutputPair,
	// status indicators
	output logic redLed,
	output logic greenLed,
	output logic [lockout_pkg::NUM_INPUTS-1:0] inputLed,
	// diagnostic display
	output logic dispDash,
	output logic dispDigitsOn,
	output logic [3:0] dispTens,
	output logic [3:0] dispOnes
);
	import lockout_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// first stages, read only by the second stages
	logic faultMeta;
	logic [7:0] codeMeta;
	logic kindMeta;
	logic [IDX_W-1:0] idxMeta;
	logic resetMeta;
	logic muteMeta;
	logic [NUM_INPUTS-1:0] activeMeta;
	// second stages, safe for logic
	logic faultSync;
	logic [7:0] codeSync;
	logic kindSync;
	logic [IDX_W-1:0] idxSync;
	logic muteSync;
	logic [NUM_INPUTS-1:0] activeSync;

	// carrier to the reset qualifier
	reset_qual_if rq ();

	// two flops on every pin; code and index may tear, but fault is late anyway
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			faultMeta <= 1'b0;
			codeMeta <= 8'h00;
			kindMeta <= 1'b0;
			idxMeta <= '0;
			resetMeta <= 1'b0;
			muteMeta <= 1'b0;
			activeMeta <= '0;
			faultSync <= 1'b0;
			codeSync <= 8'h00;
			kindSync <= 1'b0;
			idxSync <= '0;
			rq.closed <= 1'b0;
			muteSync <= 1'b0;
			activeSync <= '0;
		end else begin
			faultMeta <= faultIn;
			codeMeta <= faultCode;
			kindMeta <= faultIsInput;
			idxMeta <= faultIdx;
			resetMeta <= resetClosed;
			muteMeta <= muteActive;
			activeMeta <= activeIn;
			faultSync <= faultMeta;
			codeSync <= codeMeta;
			kindSync <= kindMeta;
			idxSync <= idxMeta;
			rq.closed <= resetMeta;
			muteSync <= muteMeta;
			activeSync <= activeMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// helpers

	// reset closure judge
	reset_qualifier #(
		.MIN_CYCLES(RESET_MIN),
		.MAX_CYCLES(RESET_MAX)
	) u_qual (
		.clk(clk),
		.rst(rst),
		.rq(rq)
	);

	// shared flash phase
	logic flashPhase;
	blink_timer #(
		.HALF_CYCLES(FLASH_HALF)
	) u_blink (
		.clk(clk),
		.rst(rst),
		.phase(flashPhase)
	);

	// address match, used by both the write and read paths
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
		hit = (a == target);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control register

	// software run enable and forced lockout
	logic [1:0] ctrl;
	logic runEnable;
	logic forceLock;
	assign runEnable = ctrl[CTRL_RUN_BIT];
	assign forceLock = ctrl[CTRL_FORCE_BIT];

	// outputs stay off until software enables the run
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ctrl <= CTRL_RESET;
		else if (wrStrobe && hit(addr, ADDR_CTRL))
			ctrl <= wrData[1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// lockout state machine

	// current and next mode
	mode_t mode;
	mode_t next_mode;
	// any fault source, hardware or software
	logic faultAny;
	// latched error code for the display
	logic [7:0] lockCode;
	// fault was tied to one input that must be cycled
	logic lockByInput;
	logic [IDX_W-1:0] lockIdx;
	// offending input seen inactive since the fault cleared
	logic sawOff;
	// offending input reopened then re-activated
	logic cycleDone;
	// one-cycle events for the status register
	logic [EV_W-1:0] events;

	assign faultAny = faultSync || forceLock;
	assign cycleDone = lockByInput && sawOff && activeSync[lockIdx];

	// next mode decision
	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_RUN: begin
				if (faultAny)
					next_mode = MODE_LOCK;
			end
			MODE_LOCK: begin
				if (!faultAny)
					next_mode = MODE_CLEARWAIT;
			end
			MODE_CLEARWAIT: begin
				// a returning fault sends it back
				if (faultAny)
					next_mode = MODE_LOCK;
				else if (cycleDone || rq.valid)
					next_mode = MODE_RUN;
			end
			default: next_mode = MODE_LOCK;
		endcase
	end

	// mode register; reset lands in run with outputs still gated by ctrl
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mode <= MODE_RUN;
		else
			mode <= next_mode;
	end

	// capture error code and offending input on entry from run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lockCode <= CODE_NONE;
			lockByInput <= 1'b0;
			lockIdx <= '0;
		end else if (mode == MODE_RUN && next_mode == MODE_LOCK) begin
			lockCode <= faultSync ? codeSync : CODE_FORCED;
			lockByInput <= faultSync && kindSync;
			lockIdx <= idxSync;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sawOff <= 1'b0;
		else if (mode != MODE_CLEARWAIT)
			sawOff <= 1'b0;
		else if (!activeSync[lockIdx])
			sawOff <= 1'b1;
	end

	// events derived from mode changes and qualifier judgements
	always_comb begin
		events = '0;
		events[EV_LOCKOUT] = (mode == MODE_RUN) && (next_mode == MODE_LOCK);
		events[EV_ACCEPT] = (mode == MODE_CLEARWAIT) && (next_mode == MODE_RUN);
		events[EV_REJECT] = rq.reject || (rq.valid && mode != MODE_CLEARWAIT);
		events[EV_CLEARED] = (mode == MODE_LOCK) && (next_mode == MODE_CLEARWAIT);
	end

	////////////////////////////////////////////////////////////////////////
	// status, mask and interrupt

	// sticky events and their mask
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic [EV_W-1:0] next_status;
	logic statusRead;

	assign statusRead = rdStrobe && hit(addr, ADDR_STATUS);

	// read clears what was seen; a new event in the same cycle still sets
	always_comb begin
		next_status = statusRead ? EV_RESET : status;
		next_status = next_status | events;
	end

	// status register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			status <= EV_RESET;
		else
			status <= next_status;
	end

	// mask register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			mask <= EV_RESET;
		else if (wrStrobe && hit(addr, ADDR_MASK))
			mask <= wrData[EV_W-1:0];
	end

	// level interrupt, one cycle behind the status bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	////////////////////////////////////////////////////////////////////////
	// register read port

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= '0;
		end else begin
			rdData <= '0;
			if (rdStrobe) begin
				case (addr)
					ADDR_CTRL: rdData[1:0] <= ctrl;
					ADDR_STATUS: rdData[EV_W-1:0] <= status;
					ADDR_MASK: rdData[EV_W-1:0] <= mask;
					ADDR_STATE: begin
						rdData[ST_LOCK_BIT] <= (mode != MODE_RUN);
						rdData[ST_OUT_BIT] <= safetyOutputPair[0];
						rdData[ST_FAULT_BIT] <= faultAny;
						rdData[ST_CODE_LSB +: 8] <= lockCode;
					end
					// unmapped reads return zero
					default: rdData <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// safety outputs and indicators

	// both channels switch together; keyed on the current mode so they come on with the digits blanking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			safetyOutputPair <= 2'b00;
			greenLed <= 1'b0;
		end else begin
			// off outside run, fault drops them at once
			safetyOutputPair <= {2{mode == MODE_RUN && runEnable && !faultAny}};
			greenLed <= mode == MODE_RUN && runEnable && !faultAny;
		end
	end

	// red indicator flashes in lockout, steady when stopped by software
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			redLed <= 1'b1;
		else if (mode != MODE_RUN)
			redLed <= flashPhase;
		else
			redLed <= !runEnable;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			inputLed <= '0;
		else
			inputLed <= activeSync;
	end

	////////////////////////////////////////////////////////////////////////
	// diagnostic display

	// digits only in lockout, dash otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dispDash <= 1'b1;
			dispDigitsOn <= 1'b0;
			dispTens <= 4'h0;
			dispOnes <= 4'h0;
		end else if (mode != MODE_RUN) begin
			dispDash <= 1'b0;
			dispDigitsOn <= 1'b1;
			dispTens <= lockCode[7:4];
			dispOnes <= lockCode[3:0];
		end else begin
			dispDigitsOn <= 1'b0;
			dispTens <= 4'h0;
			dispOnes <= 4'h0;
			dispDash <= muteSync ? flashPhase : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== lockout_reset_status_logic_chk.sv ====
// port checker of the lockout, reset and status logic
`timescale 1ns/100ps
`default_nettype none
module lockout_reset_status_logic_chk #(
	parameter int RESET_MIN = 20,
	parameter int RESET_MAX = 80,
	parameter int FLASH_HALF = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins in
	input wire logic faultIn,
	input wire logic muteActive,
	input wire logic [7:0] activeIn,
	// pins out
	input wire logic [1:0] safetyOutputPair,
	input wire logic redLed,
	input wire logic greenLed,
	input wire logic [7:0] inputLed,
	input wire logic dispDash,
	input wire logic dispDigitsOn,
	input wire logic [3:0] dispTens,
	input wire logic [3:0] dispOnes
);
	// one domain, so clock and disable are given once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	// two sync flops plus the output flop
	a_fault_stops_out: assert property (
		$rose(faultIn) |-> ##3 safetyOutputPair == 2'b00)
		else $error("outputs not off after fault");
	a_pair_same: assert property (
		safetyOutputPair[0] == safetyOutputPair[1])
		else $error("output pair split");
	a_digits_mean_lock: assert property (
		dispDigitsOn |-> safetyOutputPair == 2'b00 && !dispDash)
		else $error("digits shown while not locked");
	a_digits_blank: assert property (
		!dispDigitsOn |-> dispTens == 4'h0 && dispOnes == 4'h0)
		else $error("digit value without error");
	a_green_out: assert property (
		greenLed == safetyOutputPair[0])
		else $error("green does not follow outputs");
	a_input_led: assert property (
		inputLed == $past(activeIn, 3))
		else $error("input indicator wrong");
	// a steady red for six cycles means no flashing
	a_red_flash: assert property (
		(dispDigitsOn && $stable(redLed))[*6] |-> 1'b0)
		else $error("red not flashing in lockout");
	a_dash_steady: assert property (
		(safetyOutputPair == 2'b11 && !muteActive)[*4] |-> dispDash)
		else $error("dash not steady");
endmodule
bind lockout_reset_status_logic lockout_reset_status_logic_chk #(
	.RESET_MIN(RESET_MIN),
	.RESET_MAX(RESET_MAX),
	.FLASH_HALF(FLASH_HALF)
) chk (.clk, .rst, .faultIn, .muteActive, .activeIn, .safetyOutputPair, .redLed,
	.greenLed, .inputLed, .dispDash, .dispDigitsOn, .dispTens, .dispOnes);
`default_nettype wire

// ==== operator_switch.sv ====
// operator reset switch closing for a commanded count of cycles
`timescale 1ns/100ps
`default_nettype none
module operator_switch (
	// clock
	input wire logic clk,
	// command from the bench
	input wire logic press,
	input wire logic [7:0] holdCycles,
	// contact, high while closed
	output logic resetClosed
);
	// closed cycles still to run
	logic [7:0] left = 8'h00;
	initial resetClosed = 1'b0;
	always @(posedge clk) begin
		if (press && !resetClosed) begin
			resetClosed <= 1'b1;
			left <= holdCycles - 8'h01;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end else begin
			resetClosed <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== lockout_reset_status_logic_tb.sv ====
// self-checking bench of the lockout, reset and status logic
`timescale 1ns/100ps
`default_nettype none
module lockout_reset_status_logic_tb;
	import lockout_pkg::*;
	// clock and reset
	logic clk = 1'b0;
	logic rst = 1'b1;
	// pins
	logic faultIn = 1'b0;
	logic [7:0] faultCode = 8'h00;
	logic faultIsInput = 1'b0;
	logic [IDX_W-1:0] faultIdx = 3'h0;
	logic resetClosed;
	logic muteActive = 1'b0;
	logic [NUM_INPUTS-1:0] activeIn = 8'h00;
	// register port
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] wrData = 32'h0;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic [DATA_W-1:0] rdData;
	logic irq;
	// outputs
	logic [1:0] safetyOutputPair;
	logic redLed, greenLed, dispDash, dispDigitsOn;
	logic [NUM_INPUTS-1:0] inputLed;
	logic [3:0] dispTens, dispOnes;
	// switch command and counters
	logic press = 1'b0;
	logic [7:0] holdCycles = 8'h00;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	// short windows keep the run brief
	lockout_reset_status_logic #(.RESET_MIN(20), .RESET_MAX(80), .FLASH_HALF(4)) dut (
		.clk, .rst, .faultIn, .faultCode, .faultIsInput, .faultIdx, .resetClosed,
		.muteActive, .activeIn, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .irq,
		.safetyOutputPair, .redLed, .greenLed, .inputLed, .dispDash, .dispDigitsOn,
		.dispTens, .dispOnes);
	operator_switch sw (.clk, .press, .holdCycles, .resetClosed);
	////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, far above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			summarize();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		chk(what, exp, rdData);
	endtask
	// closure of n cycles, then time for judging
	task automatic pr(input logic [7:0] n);
		@(posedge clk);
		press <= 1'b1;
		holdCycles <= n;
		@(posedge clk);
		press <= 1'b0;
		cyc(int'(n) + 10);
	endtask
	task automatic outs(input logic [1:0] p, input logic d);
		chk("pair", p, safetyOutputPair);
		chk("digits on", d, dispDigitsOn);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_power;
		outs(2'b00, 1'b0);
		chk("red", 1'b1, redLed);
		rd(ADDR_CTRL, 32'h0, "ctrl");
		rd(ADDR_MASK, 32'h0, "mask");
		rd(8'h10, 32'h0, "unmapped");
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_MASK, 32'hF);
		cyc(4);
		outs(2'b11, 1'b0);
		chk("dash", 1'b1, dispDash);
		chk("green", 1'b1, greenLed);
		chk("red off", 1'b0, redLed);
		rd(ADDR_STATE, 32'h2, "state");
		// a good closure while running leaves the outputs on but is flagged as a reject
		pr(40);
		outs(2'b11, 1'b0);
		rd(ADDR_STATUS, 32'h4, "status");
		$display("test power done");
	endtask
	task automatic t_window;
		faultCode <= 8'h31;
		faultIn <= 1'b1;
		cyc(4);
		outs(2'b00, 1'b1);
		chk("code", 8'h31, {dispTens, dispOnes});
		chk("irq", 1'b1, irq);
		rd(ADDR_STATUS, 32'h1, "status");
		pr(40);
		outs(2'b00, 1'b1);
		faultIn <= 1'b0;
		cyc(5);
		rd(ADDR_STATUS, 32'hC, "status");
		wr(ADDR_MASK, 32'h0);
		// just outside both ends of the window
		foreach (holdCycles[i]) begin
			if (i < 2) begin
				pr(i == 0 ? 8'd19 : 8'd81);
				outs(2'b00, 1'b1);
				chk("irq masked", 1'b0, irq);
				rd(ADDR_STATUS, 32'h4, "status");
			end
		end
		wr(ADDR_MASK, 32'hF);
		pr(20);
		outs(2'b11, 1'b0);
		chk("irq", 1'b1, irq);
		rd(ADDR_STATUS, 32'h2, "status");
		cyc(3);
		chk("irq", 1'b0, irq);
		$display("test window done");
	endtask
	task automatic t_cycle;
		activeIn <= 8'hFF;
		faultIsInput <= 1'b1;
		faultIdx <= 3'h2;
		faultCode <= 8'h51;
		faultIn <= 1'b1;
		cyc(4);
		chk("code", 8'h51, {dispTens, dispOnes});
		faultIn <= 1'b0;
		cyc(6);
		outs(2'b00, 1'b1);
		activeIn <= 8'hFB;
		cyc(5);
		activeIn <= 8'hFF;
		cyc(6);
		outs(2'b11, 1'b0);
		chk("input leds", 8'hFF, inputLed);
		rd(ADDR_STATUS, 32'hB, "status");
		faultIsInput <= 1'b0;
		$display("test cycle done");
	endtask
	task automatic t_forced;
		wr(ADDR_CTRL, 32'h3);
		cyc(4);
		outs(2'b00, 1'b1);
		chk("code", CODE_FORCED, {dispTens, dispOnes});
		wr(ADDR_CTRL, 32'h1);
		pr(80);
		outs(2'b11, 1'b0);
		$display("test forced done");
	endtask
	task automatic t_mute;
		int flips;
		logic prevDash;
		flips = 0;
		activeIn <= 8'hA5;
		muteActive <= 1'b1;
		cyc(4);
		prevDash = dispDash;
		repeat (30) begin
			cyc(1);
			if (dispDash !== prevDash)
				flips++;
			prevDash = dispDash;
		end
		chk("dash flashes", 1'b1, flips > 4);
		chk("input leds", 8'hA5, inputLed);
		muteActive <= 1'b0;
		cyc(6);
		chk("dash", 1'b1, dispDash);
		$display("test mute done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		t_power();
		t_window();
		t_cycle();
		t_forced();
		t_mute();
		summarize();
	end
endmodule
`default_nettype wire
